//--- dv/rcrb_checker.sv
`timescale 1ns/10ps
module rcrb_checker (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic [7:0]          regAddr,
  input wire logic [7:0]          regWdata,
  input wire logic                regWrite,
  input wire logic                regRead,
  input wire logic [7:0]          regRdata,
  input wire logic [6:0]          queueFill,
  input wire logic [7:0]          refCountB,
  input wire logic [7:0]          feedbackCountB,
  input wire rcrb_pkg::rcrb_cfg_t cfg,
  input wire logic                irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_RATE_TOP_ZERO: assert property (
    regRead && regAddr == rcrb_pkg::ADDR_BITRATE |=> !regRdata[7]) else $error("rate bit 7 set");
  AST_DEV_LOAD: assert property (
    regWrite && regAddr == rcrb_pkg::ADDR_DEVIATION |-> ##2
    cfg.deviationValue == $past(regWdata, 2)) else $error("deviation not loaded");
  AST_DEV_DIV: assert property (
    cfg.deviationDivisor == 9'(cfg.deviationValue) + 9'h001) else $error("deviation divisor");
  AST_RATE_LOAD: assert property (
    regWrite && regAddr == rcrb_pkg::ADDR_BITRATE |-> ##2
    cfg.rateDividerValue == $past(regWdata[6:0], 2)) else $error("rate not loaded");
  AST_RATE_DIV: assert property (
    cfg.rateDivisor == 8'(cfg.rateDividerValue) + 8'h01) else $error("rate divisor");
  AST_GAIN: assert property (
    cfg.ifAttenHalfDb == 6'(9 * cfg.intermediateGainSel)) else $error("gain attenuation");
  AST_FLOOR: assert property (
    regWrite && regAddr == rcrb_pkg::ADDR_FLOOR |-> ##2
    cfg.onoffFloorValue == $past(regWdata, 2)) else $error("floor not loaded");
  AST_FIFO: assert property (
    regWrite && regAddr == rcrb_pkg::ADDR_FIFOSETUP |-> ##2
    cfg.queueDepthBytes == 7'(16 * ($past(regWdata[7:6], 2) + 1)) &&
    cfg.queueLevelIrqPoint == $past(regWdata[5:0], 2)) else $error("fifo setup");
  AST_SET_B: assert property (
    !cfg.refSetAActive |-> cfg.refCount == $past(refCountB) &&
    cfg.feedbackCount == $past(feedbackCountB)) else $error("set b not applied");
  COV_IRQ: cover property ($rose(irq));
  COV_PACKET: cover property (cfg.dataMode == rcrb_pkg::RCRB_DM_PACKET);
  COV_SET_B: cover property (!cfg.refSetAActive);
endmodule
bind rcrb_top rcrb_checker chk (.clock, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
  .regRdata, .queueFill, .refCountB, .feedbackCountB, .cfg, .irq);

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                clock = 0, rst_n = 0, regWrite = 0, regRead = 0, irq;
  logic [7:0]          regAddr = 8'h00, regWdata = 8'h00, regRdata, a, v;
  logic [7:0]          refCountB = 8'h5a, feedbackCountB = 8'ha5;
  logic [6:0]          queueFill = 7'h00;
  rcrb_pkg::rcrb_cfg_t cfg;
  logic [31:0]         seed = 32'h206be5c8;
  logic [7:0]          shadow [8] = '{8'h28, 8'h88, 8'h03, 8'h07, 8'h0c, 8'h0f, 8'h77, 8'h64};
  int                  failures = 0, check_count = 0, cycles = 0, i;
  rcrb_top dut (.clock, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .queueFill, .refCountB, .feedbackCountB, .cfg, .irq);
  initial forever #2 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic rcrb_pkg::rcrb_datamode_t exp_mode(logic upper, logic lower);
    if (upper) return rcrb_pkg::RCRB_DM_PACKET;
    return lower ? rcrb_pkg::RCRB_DM_BUFFER : rcrb_pkg::RCRB_DM_CONT;
  endfunction
  task automatic check(string name, logic [15:0] seen, logic [15:0] expv);
    check_count++;
    if (seen !== expv) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    regAddr <= ad;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    // one idle edge so a following write never re-raises the strobe in this step
    @(posedge clock);
  endtask
  task automatic rdc(logic [7:0] ad, logic [7:0] expv);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    check($sformatf("reg %h", ad), regRdata, expv);
    @(posedge clock);
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wait_irq(logic [7:0] st);
    int n;
    for (n = 0; n < 10 && irq !== 1'b1; n++) @(negedge clock);
    check("irq", irq, 16'h1);
    @(posedge clock);
    rdc(8'h20, st);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    // look at settled outputs, away from the launching edge
    @(negedge clock);
    check("kind", cfg.onoffThresholdKind, rcrb_pkg::RCRB_TH_PEAK);
    check("depth", cfg.queueDepthBytes, 16'd16);
    check("seta", cfg.refSetAActive, 16'h1);
    check("rdata", regRdata, 16'h0);
    check("irqrst", irq, 16'h0);
    @(posedge clock);
    for (i = 0; i < 8; i++) rdc(8'(i), shadow[i]);
    for (i = 0; i < 40; i++) begin
      v = 8'(rnd());
      a = 8'(rnd() % 6) + 8'h02;
      wr(a, v);
      shadow[a] = (a == 8'h03) ? (v & 8'h7f) : v;
      rdc(a, shadow[a]);
    end
    for (i = 0; i < 16; i++) begin
      wr(8'h01, {2'b10, i[1], i[3:2], i[0], i[3:2]});
      settle();
      check("kind", cfg.onoffThresholdKind, 16'(i[3:2]));
      check("mode", cfg.dataMode, exp_mode(i[0], i[1]));
      check("atten", cfg.ifAttenHalfDb, 16'(9 * i[3:2]));
      @(posedge clock);
    end
    wr(8'h03, 8'hff);
    rdc(8'h03, 8'h7f);
    wr(8'h40, 8'h55);
    rdc(8'h40, 8'h00);
    rdc(8'h22, 8'h00);
    refCountB <= 8'(rnd());
    feedbackCountB <= 8'(rnd());
    wr(8'h00, 8'h29);
    settle();
    check("refb", cfg.refCount, refCountB);
    check("fbb", cfg.feedbackCount, feedbackCountB);
    @(posedge clock);
    wr(8'h00, 8'h28);
    settle();
    check("refa", cfg.refCount, shadow[6]);
    check("fba", cfg.feedbackCount, shadow[7]);
    @(posedge clock);
    wr(8'h05, 8'h0f);
    wr(8'h21, 8'h01);
    wr(8'h22, 8'h07);
    queueFill <= 7'd20;
    wait_irq(8'h01);
    wr(8'h22, 8'h07);
    settle();
    check("irq", irq, 16'h0);
    @(posedge clock);
    wr(8'h00, 8'h88);
    wr(8'h22, 8'h07);
    queueFill <= 7'd10;
    wait_irq(8'h01);
    wr(8'h21, 8'h00);
    wr(8'h00, 8'h68);
    wr(8'h22, 8'h01);
    queueFill <= 7'd30;
    settle();
    check("masked", irq, 16'h0);
    @(posedge clock);
    rdc(8'h20, 8'h03);
    rdc(8'h21, 8'h00);
    rdc(8'h23, 8'h1e);
    give_verdict();
  end
endmodule

//--- hdl/rcrb_level_detect.sv
`timescale 1ns/10ps
// fifo threshold event generator, direction depends on operating mode
module rcrb_level_detect (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire rcrb_pkg::rcrb_opmode_t opMode,
  input  wire logic [6:0]            fillLevel,
  input  wire logic [5:0]            thresholdPoint,
  output logic                       levelEvent
);

  typedef struct packed {
    logic above;
  } rcrb_lvl_state_t;

  rcrb_lvl_state_t state_q;
  rcrb_lvl_state_t state_d;
  logic            cond;

  always_comb begin
    state_d = state_q;
    cond    = 1'b0;
    case (opMode)
      // transmit: fires when fill drains to the point
      rcrb_pkg::RCRB_OP_TRANSMIT: cond = fillLevel <= {1'b0, thresholdPoint};
      // receive and standby: fires when fill exceeds the point
      rcrb_pkg::RCRB_OP_RECEIVE:  cond = fillLevel > {1'b0, thresholdPoint};
      rcrb_pkg::RCRB_OP_STANDBY:  cond = fillLevel > {1'b0, thresholdPoint};
      default:                    cond = 1'b0;
    endcase
    state_d.above = cond;
    levelEvent = cond & ~state_q.above;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

//--- hdl/rcrb_pkg.sv
package rcrb_pkg;

  localparam logic [7:0] ADDR_GENERAL    = 8'h00;
  localparam logic [7:0] ADDR_DATAMOD    = 8'h01;
  localparam logic [7:0] ADDR_DEVIATION  = 8'h02;
  localparam logic [7:0] ADDR_BITRATE    = 8'h03;
  localparam logic [7:0] ADDR_FLOOR      = 8'h04;
  localparam logic [7:0] ADDR_FIFOSETUP  = 8'h05;
  localparam logic [7:0] ADDR_REFDIVA    = 8'h06;
  localparam logic [7:0] ADDR_FBDIVA     = 8'h07;
  localparam logic [7:0] ADDR_IRQSTATUS  = 8'h20;
  localparam logic [7:0] ADDR_IRQENABLE  = 8'h21;
  localparam logic [7:0] ADDR_IRQCLEAR   = 8'h22;
  localparam logic [7:0] ADDR_QLEVEL     = 8'h23;

  localparam logic [7:0] RST_GENERAL     = 8'h28;
  localparam logic [7:0] RST_DATAMOD     = 8'h88;
  localparam logic [7:0] RST_DEVIATION   = 8'h03;
  localparam logic [6:0] RST_RATE        = 7'h07;
  localparam logic [7:0] RST_FLOOR       = 8'h0c;
  localparam logic [7:0] RST_FIFOSETUP   = 8'h0f;
  localparam logic [7:0] RST_REFDIVA     = 8'h77;
  localparam logic [7:0] RST_FBDIVA      = 8'h64;

  // field positions
  localparam int GEN_SELECT_BIT    = 0;
  localparam int GEN_CMODE_LSB     = 5;
  localparam int DM_LOWER_BIT      = 5;
  localparam int DM_UPPER_BIT      = 2;
  localparam int DM_KIND_LSB       = 3;
  localparam int DM_GAIN_LSB       = 0;
  localparam int FS_DEPTH_LSB      = 6;
  localparam int FS_POINT_LSB      = 0;

  localparam logic [2:0] CMODE_STANDBY = 3'h1;
  localparam logic [2:0] CMODE_RECEIVE = 3'h3;
  localparam logic [2:0] CMODE_TRANSMIT = 3'h4;

  localparam int IRQ_BITS = 3;
  localparam int IRQ_LEVEL_BIT = 0;
  localparam int IRQ_WRITE_BIT = 1;
  localparam int IRQ_RESV_BIT  = 2;

  localparam real XTAL_REF_MHZ = 12.8;

  typedef enum logic [1:0] {
    RCRB_TH_FIXED   = 2'h0,
    RCRB_TH_PEAK    = 2'h1,
    RCRB_TH_AVERAGE = 2'h2,
    RCRB_TH_RESV    = 2'h3
  } rcrb_thresh_t;

  typedef enum logic [2:0] {
    RCRB_DM_CONT   = 3'b001,
    RCRB_DM_BUFFER = 3'b010,
    RCRB_DM_PACKET = 3'b100
  } rcrb_datamode_t;

  typedef enum logic [2:0] {
    RCRB_OP_STANDBY  = 3'b001,
    RCRB_OP_RECEIVE  = 3'b010,
    RCRB_OP_TRANSMIT = 3'b100
  } rcrb_opmode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcrb_bus_req_t;

  typedef struct packed {
    rcrb_thresh_t   onoffThresholdKind;
    rcrb_datamode_t dataMode;
    logic [1:0]     intermediateGainSel;
    logic [5:0]     ifAttenHalfDb;
    logic [7:0]     deviationValue;
    logic [8:0]     deviationDivisor;
    logic [6:0]     rateDividerValue;
    logic [7:0]     rateDivisor;
    logic [7:0]     onoffFloorValue;
    logic [6:0]     queueDepthBytes;
    logic [5:0]     queueLevelIrqPoint;
    logic [7:0]     refCount;
    logic [7:0]     feedbackCount;
    logic           refSetAActive;
  } rcrb_cfg_t;

endpackage

//--- hdl/rcrb_top.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module rcrb_top (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic [7:0]                regRdata,
  input  wire logic [6:0]           queueFill,
  input  wire logic [7:0]           refCountB,
  input  wire logic [7:0]           feedbackCountB,
  output rcrb_pkg::rcrb_cfg_t       cfg,
  output logic                      irq
);

  typedef struct packed {
    logic [7:0]          general_setup_register;
    logic [7:0]          data_modulation_config;
    logic [7:0]          freq_deviation_value;
    logic [6:0]          bit_rate_divider;
    logic [7:0]          ook_floor_level;
    logic [7:0]          fifo_setup;
    logic [7:0]          pll_ref_divider_a;
    logic [7:0]          pll_feedback_divider_a;
    logic [2:0]          irqStatus;
    logic [2:0]          irqEnable;
    logic [7:0]          rdata;
    rcrb_pkg::rcrb_cfg_t cfg;
  } rcrb_state_t;

  rcrb_state_t           state_q;
  rcrb_state_t           state_d;
  rcrb_pkg::rcrb_bus_req_t req;
  rcrb_pkg::rcrb_opmode_t  opMode;
  logic                  levelEvent;
  logic [2:0]            irqEvents;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic rcrb_pkg::rcrb_datamode_t decodeMode(input logic [7:0] dm);
    if (dm[rcrb_pkg::DM_UPPER_BIT]) begin
      decodeMode = rcrb_pkg::RCRB_DM_PACKET;
    end else if (dm[rcrb_pkg::DM_LOWER_BIT]) begin
      decodeMode = rcrb_pkg::RCRB_DM_BUFFER;
    end else begin
      decodeMode = rcrb_pkg::RCRB_DM_CONT;
    end
  endfunction

  function automatic rcrb_pkg::rcrb_opmode_t decodeOp(input logic [2:0] cm);
    case (cm)
      rcrb_pkg::CMODE_TRANSMIT: decodeOp = rcrb_pkg::RCRB_OP_TRANSMIT;
      rcrb_pkg::CMODE_RECEIVE:  decodeOp = rcrb_pkg::RCRB_OP_RECEIVE;
      default:                  decodeOp = rcrb_pkg::RCRB_OP_STANDBY;
    endcase
  endfunction

  assign req.addr  = regAddr;
  assign req.wdata = regWdata;
  assign req.wr    = regWrite;
  assign req.rd    = regRead;

  assign opMode = decodeOp(state_q.general_setup_register[rcrb_pkg::GEN_CMODE_LSB +: 3]);

  rcrb_level_detect u_level (
    .clock          (clock),
    .rst_n          (rst_n),
    .opMode         (opMode),
    .fillLevel      (queueFill),
    .thresholdPoint (state_q.fifo_setup[rcrb_pkg::FS_POINT_LSB +: 6]),
    .levelEvent     (levelEvent)
  );

  always_comb begin
    irqEvents = '0;
    irqEvents[rcrb_pkg::IRQ_LEVEL_BIT] = levelEvent;
    irqEvents[rcrb_pkg::IRQ_WRITE_BIT] = req.wr &
      (hit(req.addr, rcrb_pkg::ADDR_GENERAL) | hit(req.addr, rcrb_pkg::ADDR_REFDIVA) |
       hit(req.addr, rcrb_pkg::ADDR_FBDIVA));
  end

  always_comb begin
    state_d = state_q;
    state_d.rdata = 8'h00;
    if (req.wr) begin
      case (req.addr)
        rcrb_pkg::ADDR_GENERAL:   state_d.general_setup_register = req.wdata;
        rcrb_pkg::ADDR_DATAMOD:   state_d.data_modulation_config = req.wdata;
        rcrb_pkg::ADDR_DEVIATION: state_d.freq_deviation_value = req.wdata;
        rcrb_pkg::ADDR_BITRATE:   state_d.bit_rate_divider = req.wdata[6:0];
        rcrb_pkg::ADDR_FLOOR:     state_d.ook_floor_level = req.wdata;
        rcrb_pkg::ADDR_FIFOSETUP: state_d.fifo_setup = req.wdata;
        rcrb_pkg::ADDR_REFDIVA:   state_d.pll_ref_divider_a = req.wdata;
        rcrb_pkg::ADDR_FBDIVA:    state_d.pll_feedback_divider_a = req.wdata;
        rcrb_pkg::ADDR_IRQENABLE: state_d.irqEnable = req.wdata[2:0];
        rcrb_pkg::ADDR_IRQCLEAR:  state_d.irqStatus = state_q.irqStatus & ~req.wdata[2:0];
        default:                  state_d.rdata = 8'h00;
      endcase
    end
    // set wins over clear
    state_d.irqStatus = state_d.irqStatus | irqEvents;
    if (req.rd) begin
      case (req.addr)
        rcrb_pkg::ADDR_GENERAL:   state_d.rdata = state_q.general_setup_register;
        rcrb_pkg::ADDR_DATAMOD:   state_d.rdata = state_q.data_modulation_config;
        rcrb_pkg::ADDR_DEVIATION: state_d.rdata = state_q.freq_deviation_value;
        rcrb_pkg::ADDR_BITRATE:   state_d.rdata = {1'b0, state_q.bit_rate_divider};
        rcrb_pkg::ADDR_FLOOR:     state_d.rdata = state_q.ook_floor_level;
        rcrb_pkg::ADDR_FIFOSETUP: state_d.rdata = state_q.fifo_setup;
        rcrb_pkg::ADDR_REFDIVA:   state_d.rdata = state_q.pll_ref_divider_a;
        rcrb_pkg::ADDR_FBDIVA:    state_d.rdata = state_q.pll_feedback_divider_a;
        rcrb_pkg::ADDR_IRQSTATUS: state_d.rdata = {5'h00, state_q.irqStatus};
        rcrb_pkg::ADDR_IRQENABLE: state_d.rdata = {5'h00, state_q.irqEnable};
        rcrb_pkg::ADDR_QLEVEL:    state_d.rdata = {1'b0, queueFill};
        default:                  state_d.rdata = 8'h00;
      endcase
    end
    // decoded configuration, registered
    state_d.cfg.onoffThresholdKind = rcrb_pkg::rcrb_thresh_t'(
      state_q.data_modulation_config[rcrb_pkg::DM_KIND_LSB +: 2]);
    state_d.cfg.dataMode = decodeMode(state_q.data_modulation_config);
    state_d.cfg.intermediateGainSel =
      state_q.data_modulation_config[rcrb_pkg::DM_GAIN_LSB +: 2];
    // attenuation in half dB: 0, 9, 18, 27
    state_d.cfg.ifAttenHalfDb = 6'(9 * state_d.cfg.intermediateGainSel);
    state_d.cfg.deviationValue = state_q.freq_deviation_value;
    state_d.cfg.deviationDivisor = {1'b0, state_q.freq_deviation_value} + 9'h001;
    state_d.cfg.rateDividerValue = state_q.bit_rate_divider;
    state_d.cfg.rateDivisor = {1'b0, state_q.bit_rate_divider} + 8'h01;
    state_d.cfg.onoffFloorValue = state_q.ook_floor_level;
    state_d.cfg.queueDepthBytes = 7'({state_q.fifo_setup[rcrb_pkg::FS_DEPTH_LSB +: 2], 4'h0})
      + 7'h10;
    state_d.cfg.queueLevelIrqPoint = state_q.fifo_setup[rcrb_pkg::FS_POINT_LSB +: 6];
    state_d.cfg.refSetAActive =
      ~state_q.general_setup_register[rcrb_pkg::GEN_SELECT_BIT];
    if (state_d.cfg.refSetAActive) begin
      state_d.cfg.refCount      = state_q.pll_ref_divider_a;
      state_d.cfg.feedbackCount = state_q.pll_feedback_divider_a;
    end else begin
      state_d.cfg.refCount      = refCountB;
      state_d.cfg.feedbackCount = feedbackCountB;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= '0;
      state_q.general_setup_register <= rcrb_pkg::RST_GENERAL;
      state_q.data_modulation_config <= rcrb_pkg::RST_DATAMOD;
      state_q.freq_deviation_value   <= rcrb_pkg::RST_DEVIATION;
      state_q.bit_rate_divider       <= rcrb_pkg::RST_RATE;
      state_q.ook_floor_level        <= rcrb_pkg::RST_FLOOR;
      state_q.fifo_setup             <= rcrb_pkg::RST_FIFOSETUP;
      state_q.pll_ref_divider_a      <= rcrb_pkg::RST_REFDIVA;
      state_q.pll_feedback_divider_a <= rcrb_pkg::RST_FBDIVA;
      state_q.cfg.onoffThresholdKind <= rcrb_pkg::RCRB_TH_PEAK;
      state_q.cfg.dataMode           <= rcrb_pkg::RCRB_DM_CONT;
      state_q.cfg.deviationValue     <= rcrb_pkg::RST_DEVIATION;
      state_q.cfg.deviationDivisor   <= 9'h004;
      state_q.cfg.rateDividerValue   <= rcrb_pkg::RST_RATE;
      state_q.cfg.rateDivisor        <= 8'h08;
      state_q.cfg.onoffFloorValue    <= rcrb_pkg::RST_FLOOR;
      state_q.cfg.queueDepthBytes    <= 7'h10;
      state_q.cfg.queueLevelIrqPoint <= 6'h0f;
      state_q.cfg.refCount           <= rcrb_pkg::RST_REFDIVA;
      state_q.cfg.feedbackCount      <= rcrb_pkg::RST_FBDIVA;
      state_q.cfg.refSetAActive      <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdata = state_q.rdata;
  assign cfg      = state_q.cfg;
  assign irq      = |(state_q.irqStatus & state_q.irqEnable);

endmodule
